/* File: hdl/apc_checker.sv */
// ramp pulse table checker: parameter checks, ten-level ramp math, alarm words
//
// Function
// - steady frequency above 5kHz refused, frequency alarm
// - initial/steady plus others above 5kHz: total alarm
// - initial above steady frequency refused
// - alarm word B bits 4-7 initial alarms
// - alarm word B bits 8-11 ramp alarms
// - terminals not set for pulses: refused
// - group already emitting pulses: refused
// - refusal leaves table enable flag low
// - initial alarm suppresses the total alarm
// - level frequency initial plus step times index
// - level pulses: time/10 times freq/1000
// - zero level pulse count becomes one
// - ramp pulse total twice sum plus one
// - ramp total above count: ramp alarm
// - level time pulses times 1000/freq
// - summed level time above ramp time: alarm
// - ramp alarm still enables the table
// - short count: record levels that fit both ramps
// - build, flag completion, clear after request drops
// - zero initial with ramp time uses 10Hz
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module apc_checker #(
    parameter int FREQ_W = 16,
    parameter int CNT_W = 16,
    parameter int TIME_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // pulse generator side
    input wire logic [3:0] grp_emitting,
    output logic [3:0] table_exists,
    output logic [3:0] table_done,
    output logic building
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_LEVEL = 4'b0100,
        ST_FINISH = 4'b1000
    } apc_state_t;

    apc_state_t state_reg;
    logic [1:0] grp_reg;
    logic [3:0] lvl_reg;
    logic [FREQ_W-1:0] steady_reg [4];
    logic [CNT_W-1:0] count_reg [4];
    logic [FREQ_W-1:0] init_reg [4];
    logic [TIME_W-1:0] rtime_reg [4];
    logic [3:0] request_reg;
    logic [3:0] term_cfg_reg;
    logic [15:0] freq_alarm_reg;
    logic [15:0] ramp_alarm_reg;
    logic [15:0] level_fit_reg;
    logic [3:0] fit_reg;
    logic [FREQ_W-1:0] base_freq_reg;
    logic [FREQ_W-1:0] step_reg;
    logic [31:0] pulse_sum_reg;
    logic [31:0] time_sum_reg;
    logic [3:0] done_set;
    logic [3:0] exists_clr;
    logic [3:0] exists_set;

    // selected group values
    logic [FREQ_W-1:0] sel_steady;
    logic [CNT_W-1:0] sel_count;
    logic [FREQ_W-1:0] sel_init;
    logic [TIME_W-1:0] sel_rtime;
    assign sel_steady = steady_reg[grp_reg];
    assign sel_count = count_reg[grp_reg];
    assign sel_init = init_reg[grp_reg];
    assign sel_rtime = rtime_reg[grp_reg];

    // pending request search, lowest group first
    logic pend_any;
    logic [1:0] pend_grp;
    always_comb begin
        pend_any = 1'b0;
        pend_grp = 2'd0;
        for (int g = apc_pkg::GRP_COUNT - 1; g >= 0; g--) begin
            if (request_reg[g] && !table_done[g]) begin
                pend_any = 1'b1;
                pend_grp = g[1:0];
            end
        end
    end

    // sum of frequencies that other groups are putting out right now
    logic [31:0] others_freq;
    always_comb begin
        others_freq = 32'h0000_0000;
        for (int g = 0; g < apc_pkg::GRP_COUNT; g++) begin
            if (grp_emitting[g] && g[1:0] != grp_reg) begin
                others_freq = others_freq + 32'(steady_reg[g]);
            end
        end
    end

    // checks for the selected group
    logic delete_req;
    logic [FREQ_W-1:0] init_eff;
    logic init_alarm;
    logic freq_alarm;
    logic total_alarm;
    logic refuse;
    always_comb begin
        delete_req = (sel_init == '0) && (sel_rtime == '0);
        init_eff = sel_init;
        if (sel_init == '0 && sel_rtime != '0) begin
            init_eff = FREQ_W'(apc_pkg::INIT_FREQ_DEFAULT_HZ);
        end
        init_alarm = init_eff > sel_steady;
        freq_alarm = 32'(sel_steady) > apc_pkg::FREQ_LIMIT_HZ;
        total_alarm = (32'(init_eff) + others_freq > apc_pkg::FREQ_LIMIT_HZ)
            || (32'(sel_steady) + others_freq > apc_pkg::FREQ_LIMIT_HZ);
        if (init_alarm) begin
            total_alarm = 1'b0;
        end
        refuse = !term_cfg_reg[grp_reg] || grp_emitting[grp_reg]
            || freq_alarm || total_alarm || init_alarm;
    end

    // one ramp level per cycle
    logic [FREQ_W-1:0] lvl_freq;
    logic [31:0] lvl_pulse;
    logic [31:0] lvl_time;
    logic [31:0] pulse_sum_next;
    logic [31:0] time_sum_next;
    logic [47:0] time_prod;
    always_comb begin
        lvl_freq = FREQ_W'(32'(base_freq_reg) + 32'(step_reg) * 32'(lvl_reg));
        lvl_pulse = ((32'(sel_rtime) / apc_pkg::LEVEL_COUNT) * 32'(lvl_freq))
            / 32'(apc_pkg::MS_PER_SECOND);
        if (lvl_pulse == 32'h0000_0000) begin
            lvl_pulse = 32'h0000_0001;
        end
        // level time; a zero frequency gives zero time
        time_prod = 48'(lvl_pulse) * apc_pkg::MS_PER_SECOND;
        lvl_time = 32'h0000_0000;
        if (lvl_freq != '0) begin
            lvl_time = 32'(time_prod / 48'(lvl_freq));
        end
        pulse_sum_next = pulse_sum_reg + lvl_pulse;
        time_sum_next = time_sum_reg + lvl_time;
    end

    // ramp checks at the end of the build
    logic [32:0] ramp_pulses;
    logic ramp_increase;
    logic ramp_decrease;
    always_comb begin
        // both ramps plus the middle pulse
        ramp_pulses = {pulse_sum_reg, 1'b1};
        ramp_increase = ramp_pulses > 33'(sel_count);
        ramp_decrease = time_sum_reg > 32'(sel_rtime);
    end

    // sequencing
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            grp_reg <= 2'd0;
            lvl_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (pend_any) begin
                        grp_reg <= pend_grp;
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    lvl_reg <= 4'h0;
                    if (refuse || delete_req) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_LEVEL;
                    end
                end
                ST_LEVEL: begin
                    lvl_reg <= lvl_reg + 4'h1;
                    if (lvl_reg == apc_pkg::LAST_LEVEL) begin
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ramp accumulators
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            base_freq_reg <= '0;
            step_reg <= '0;
            pulse_sum_reg <= 32'h0000_0000;
            time_sum_reg <= 32'h0000_0000;
            fit_reg <= 4'h0;
        end else if (state_reg == ST_CHECK) begin
            base_freq_reg <= init_eff;
            // step is the span over ten levels
            step_reg <= FREQ_W'(32'(sel_steady - init_eff) / apc_pkg::LEVEL_COUNT);
            pulse_sum_reg <= 32'h0000_0000;
            time_sum_reg <= 32'h0000_0000;
            fit_reg <= 4'h0;
        end else if (state_reg == ST_LEVEL) begin
            pulse_sum_reg <= pulse_sum_next;
            time_sum_reg <= time_sum_next;
            // levels that fit both ramps in the count
            if ({pulse_sum_next, 1'b1} <= 33'(sel_count)) begin
                fit_reg <= lvl_reg + 4'h1;
            end
        end
    end

    // table flag events
    always_comb begin
        done_set = 4'h0;
        exists_clr = 4'h0;
        exists_set = 4'h0;
        if (state_reg == ST_CHECK) begin
            // no table while refused or rebuilding
            exists_clr[grp_reg] = 1'b1;
            done_set[grp_reg] = refuse || delete_req;
        end
        if (state_reg == ST_FINISH) begin
            exists_set[grp_reg] = 1'b1;
            done_set[grp_reg] = 1'b1;
        end
    end

    // completion handshake, one flag per group
    for (genvar g = 0; g < 4; g++) begin : g_flags
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                table_done[g] <= 1'b0;
                table_exists[g] <= 1'b0;
            end else begin
                // set wins; clear once request is gone
                if (done_set[g]) begin
                    table_done[g] <= 1'b1;
                end else if (!request_reg[g]) begin
                    table_done[g] <= 1'b0;
                end
                if (exists_set[g]) begin
                    table_exists[g] <= 1'b1;
                end else if (exists_clr[g]) begin
                    table_exists[g] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            building <= 1'b0;
        end else begin
            building <= (state_reg == ST_IDLE) ? pend_any : (state_reg != ST_FINISH);
        end
    end

    // alarm words
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            freq_alarm_reg <= apc_pkg::RST_WORD;
            ramp_alarm_reg <= apc_pkg::RST_WORD;
            level_fit_reg <= apc_pkg::RST_WORD;
        end else if (state_reg == ST_CHECK) begin
            freq_alarm_reg[apc_pkg::FA_GROUP_LSB + int'(grp_reg)] <= freq_alarm;
            freq_alarm_reg[apc_pkg::FA_TOTAL_BIT] <= total_alarm;
            ramp_alarm_reg[apc_pkg::RB_INIT_LSB + int'(grp_reg)] <= init_alarm;
            ramp_alarm_reg[apc_pkg::RB_RAMP_LSB + int'(grp_reg)] <= 1'b0;
            level_fit_reg[4*int'(grp_reg) +: 4] <= 4'h0;
        end else if (state_reg == ST_FINISH) begin
            ramp_alarm_reg[apc_pkg::RB_RAMP_LSB + int'(grp_reg)] <=
                ramp_increase || ramp_decrease;
            level_fit_reg[4*int'(grp_reg) +: 4] <= fit_reg;
        end
    end

    // register writes
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            request_reg <= 4'h0;
            term_cfg_reg <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == apc_pkg::OFF_REQUEST) begin
                for (int g = 0; g < 4; g++) begin
                    request_reg[g] <= reg_wdata[apc_pkg::REQ_LSB + 2*g];
                end
            end
            if (reg_addr == apc_pkg::OFF_TERM_CFG) begin
                term_cfg_reg <= reg_wdata[3:0];
            end
        end
    end

    // parameter words; holding them while a build reads them is up to software
    for (genvar g = 0; g < 4; g++) begin : g_params
        localparam logic [7:0] BASE = 8'(apc_pkg::OFF_GRP_BASE + 8'(g) * apc_pkg::OFF_GRP_STRIDE);
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                steady_reg[g] <= '0;
                count_reg[g] <= '0;
                init_reg[g] <= '0;
                rtime_reg[g] <= '0;
            end else if (reg_wr) begin
                if (reg_addr == BASE + 8'(apc_pkg::FLD_STEADY_FREQ)) begin
                    steady_reg[g] <= FREQ_W'(reg_wdata);
                end
                if (reg_addr == BASE + 8'(apc_pkg::FLD_PULSE_COUNT)) begin
                    count_reg[g] <= CNT_W'(reg_wdata);
                end
                if (reg_addr == BASE + 8'(apc_pkg::FLD_INIT_FREQ)) begin
                    init_reg[g] <= FREQ_W'(reg_wdata);
                end
                if (reg_addr == BASE + 8'(apc_pkg::FLD_RAMP_TIME)) begin
                    rtime_reg[g] <= TIME_W'(reg_wdata);
                end
            end
        end
    end

    // read mux; unmapped offsets read zero
    logic [15:0] rd_mux;
    logic [1:0] rd_grp;
    logic [3:0] rd_fld;
    always_comb begin
        rd_mux = 16'h0000;
        rd_grp = 2'((reg_addr - apc_pkg::OFF_GRP_BASE) >> 4);
        rd_fld = reg_addr[3:0];
        unique case (reg_addr)
            apc_pkg::OFF_FREQ_ALARM: rd_mux = freq_alarm_reg;
            apc_pkg::OFF_RAMP_ALARM: rd_mux = ramp_alarm_reg;
            apc_pkg::OFF_LEVEL_FIT: rd_mux = level_fit_reg;
            apc_pkg::OFF_TERM_CFG: rd_mux = {12'h000, term_cfg_reg};
            apc_pkg::OFF_REQUEST: begin
                for (int g = 0; g < 4; g++) begin
                    rd_mux[apc_pkg::REQ_LSB + 2*g] = request_reg[g];
                end
            end
            apc_pkg::OFF_COMPLETE: begin
                for (int g = 0; g < 4; g++) begin
                    rd_mux[apc_pkg::CMP_LSB + 2*g] = table_done[g];
                    rd_mux[apc_pkg::CMP_LSB + 2*g + 1] = table_exists[g];
                end
            end
            default: begin
                if (reg_addr >= apc_pkg::OFF_GRP_BASE && reg_addr < 8'h60) begin
                    if (rd_fld == apc_pkg::FLD_STEADY_FREQ) begin
                        rd_mux = 16'(steady_reg[rd_grp]);
                    end else if (rd_fld == apc_pkg::FLD_PULSE_COUNT) begin
                        rd_mux = 16'(count_reg[rd_grp]);
                    end else if (rd_fld == apc_pkg::FLD_INIT_FREQ) begin
                        rd_mux = 16'(init_reg[rd_grp]);
                    end else if (rd_fld == apc_pkg::FLD_RAMP_TIME) begin
                        rd_mux = 16'(rtime_reg[rd_grp]);
                    end
                end
            end
        endcase
    end

    // read data only stands in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end
endmodule

/* File: pkg/apc_pkg.sv */
// shared constants for the ramp table checker
package apc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_FREQ_ALARM = 8'h00;
    localparam logic [7:0] OFF_RAMP_ALARM = 8'h04;
    localparam logic [7:0] OFF_REQUEST = 8'h08;
    localparam logic [7:0] OFF_COMPLETE = 8'h0c;
    localparam logic [7:0] OFF_TERM_CFG = 8'h10;
    localparam logic [7:0] OFF_LEVEL_FIT = 8'h14;
    // per group parameter block: base + group * stride + field
    localparam logic [7:0] OFF_GRP_BASE = 8'h20;
    localparam logic [7:0] OFF_GRP_STRIDE = 8'h10;
    localparam logic [3:0] FLD_STEADY_FREQ = 4'h0;
    localparam logic [3:0] FLD_PULSE_COUNT = 4'h4;
    localparam logic [3:0] FLD_INIT_FREQ = 4'h8;
    localparam logic [3:0] FLD_RAMP_TIME = 4'hc;
    // field positions
    localparam int FA_GROUP_LSB = 7;
    localparam int FA_TOTAL_BIT = 15;
    localparam int RB_INIT_LSB = 4;
    localparam int RB_RAMP_LSB = 8;
    localparam int REQ_LSB = 4;
    localparam int CMP_LSB = 4;
    localparam int GRP_COUNT = 4;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    // arithmetic constants
    localparam logic [31:0] FREQ_LIMIT_HZ = 32'h0000_1388;
    localparam logic [15:0] INIT_FREQ_DEFAULT_HZ = 16'h000a;
    localparam logic [31:0] LEVEL_COUNT = 32'h0000_000a;
    localparam logic [47:0] MS_PER_SECOND = 48'h0000_0000_03e8;
    localparam logic [3:0] LAST_LEVEL = 4'h9;
endpackage

/* File: tb/apc_ctrl_model.sv */
// controller-side model: starts pulse output only on groups that hold a table
`timescale 1ns/100ps
module apc_ctrl_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // bench commands and design flags
    input wire logic [3:0] run_cmd,
    input wire logic [3:0] table_exists,
    output logic [3:0] grp_emitting
);
    // a running group keeps running even when a new request drops its table
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            grp_emitting <= 4'h0;
        end else begin
            grp_emitting <= run_cmd & (grp_emitting | table_exists);
        end
    end
endmodule

/* File: tb/apc_prop_checker.sv */
// port assertions for the ramp table checker
`timescale 1ns/100ps
module apc_prop_mon (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // pulse side
    input wire logic [3:0] grp_emitting,
    input wire logic [3:0] table_exists,
    input wire logic [3:0] table_done,
    input wire logic building
);
    logic [3:0] req_new;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_rdata_quiet:
        assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
    a_flag_readback:
        assert property (reg_rd && reg_addr == 8'h0c |=> {reg_rdata[11], reg_rdata[9],
            reg_rdata[7], reg_rdata[5]} == $past(table_exists)) else $error("bad flag word");
    for (genvar g = 0; g < 4; g++) begin : grp
        // a new request only counts when the block is idle and completion is clear
        assign req_new[g] = reg_wr && reg_addr == 8'h08 && reg_wdata[4+2*g] && !building
            && !table_done[g];
        a_exists_done:
            assert property ($rose(table_exists[g]) |-> $rose(table_done[g])) else $error("enable");
        a_request_clears:
            assert property (req_new[g] |-> ##[1:4] !table_exists[g]) else $error("stale enable");
        a_build_done:
            assert property (req_new[g] |-> ##[1:3] building ##[1:20] table_done[g])
            else $error("no completion");
        a_done_release:
            assert property ($fell(table_done[g]) |-> $past(reg_wr) && $past(reg_addr) == 8'h08
                || $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h08) else $error("early release");
        a_emit_refuse:
            assert property (grp_emitting[g] [*5] ##0 $rose(table_done[g]) |-> !table_exists[g])
            else $error("table while emitting");
        a_exists_hold:
            assert property ($fell(table_exists[g]) |-> building || $past(building))
            else $error("enable dropped idle");
    end
endmodule
bind apc_checker apc_prop_mon apc_prop_mon_inst (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .grp_emitting(grp_emitting), .table_exists(table_exists),
    .table_done(table_done), .building(building));

/* File: tb/tb.sv */
// self-checking bench for the ramp table checker
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, building;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ea = 16'h0000, eb = 16'h0000, d;
    logic [15:0] lf = 16'h0000;
    logic [3:0] run_cmd = 4'h0, grp_emitting, table_exists, table_done, ex, cfg = 4'h0;
    int fails = 0, check_count = 0, cyc = 0, st[4], pc[4], inf[4], rt[4];
    initial begin
        forever #50 mclk = ~mclk;
    end
    apc_checker apc_checker_inst (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .grp_emitting(grp_emitting), .table_exists(table_exists), .table_done(table_done),
        .building(building));
    apc_ctrl_model apc_ctrl_model_inst (.mclk(mclk), .rst_b(rst_b), .run_cmd(run_cmd),
        .table_exists(table_exists), .grp_emitting(grp_emitting));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // about 1600 cycles are needed; the ceiling leaves wide margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            $display("MISMATCH %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // reference: refusal checks, then ten-level ramp with truncating integer math
    function automatic void eval(input int g, input logic [3:0] emit);
        int f0, stp, f, p, sum, ts, oth, fit;
        logic ia, tot, bad;
        f0 = (inf[g] == 0) ? 10 : inf[g];
        oth = 0;
        for (int h = 0; h < 4; h++) begin
            oth += (h != g && emit[h]) ? st[h] : 0;
        end
        ia = f0 > st[g];
        tot = !ia && (f0 + oth > 5000 || st[g] + oth > 5000);
        ea[7+g] = st[g] > 5000;
        ea[15] = tot;
        eb[4+g] = ia;
        bad = !cfg[g] || emit[g] || ea[7+g] || tot || ia;
        stp = (st[g] - f0) / 10;
        sum = 0;
        fit = 0;
        ts = 0;
        for (int n = 0; n < 10; n++) begin
            f = f0 + stp * n;
            p = (rt[g] / 10) * f / 1000;
            p = (p == 0) ? 1 : p;
            sum += p;
            // levels whose two ramps still fit inside the output pulse count
            fit = (2 * sum + 1 <= pc[g]) ? n + 1 : fit;
            ts += p * 1000 / f;
        end
        eb[8+g] = !bad && (2 * sum + 1 > pc[g] || ts > rt[g]);
        ex[g] = !bad;
        lf[4*g +: 4] = bad ? 4'h0 : 4'(fit);
    endfunction
    task automatic setp(input int g, input int s, input int c, input int i, input int t);
        logic [7:0] b;
        b = 8'(apc_pkg::OFF_GRP_BASE + g * apc_pkg::OFF_GRP_STRIDE);
        st[g] = s;
        pc[g] = c;
        inf[g] = i;
        rt[g] = t;
        wr(b, 16'(s));
        wr(b + 8'h04, 16'(c));
        wr(b + 8'h08, 16'(i));
        wr(b + 8'h0c, 16'(t));
    endtask
    task automatic req(input int g);
        int n;
        wr(apc_pkg::OFF_REQUEST, 16'h0001 << (4 + 2 * g));
        n = 0;
        while (table_done[g] !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(16'(n < 40), 16'h0001, "completion");
        eval(g, grp_emitting);
        chk(16'(table_exists[g]), 16'(ex[g]), "table enable");
        rd(apc_pkg::OFF_FREQ_ALARM, d);
        chk(d, ea, "alarm word a");
        rd(apc_pkg::OFF_RAMP_ALARM, d);
        chk(d, eb, "alarm word b");
        rd(apc_pkg::OFF_LEVEL_FIT, d);
        chk(d, lf, "level fit");
        wr(apc_pkg::OFF_REQUEST, 16'h0000);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(table_done[g]), 16'h0000, "completion release");
    endtask
    task automatic term(input logic [3:0] c);
        cfg = c;
        wr(apc_pkg::OFF_TERM_CFG, 16'(c));
    endtask
    initial begin
        void'($urandom(15));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        // the six words at 0x00-0x14 plus one unmapped address read zero
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), d);
            chk(d, 16'h0000, "reset value");
        end
        wr(apc_pkg::OFF_FREQ_ALARM, 16'hffff);
        rd(apc_pkg::OFF_FREQ_ALARM, d);
        chk(d, 16'h0000, "read-only write");
        $display("test reset done");
        term(4'hf);
        setp(0, 500, 300, 10, 600);
        req(0);
        setp(3, 500, 300, 0, 600);
        req(3);
        $display("test example done");
        setp(2, 5001, 900, 100, 100);
        req(2);
        setp(2, 900, 900, 1000, 100);
        req(2);
        term(4'hb);
        setp(2, 900, 900, 100, 100);
        req(2);
        term(4'hf);
        $display("test refusal done");
        setp(1, 2000, 100, 100, 100);
        req(1);
        @(posedge mclk);
        run_cmd <= 4'h2;
        repeat (3) @(posedge mclk);
        req(1);
        setp(2, 3500, 900, 100, 100);
        req(2);
        setp(2, 3500, 900, 4000, 100);
        req(2);
        @(posedge mclk);
        run_cmd <= 4'h0;
        $display("test emitting done");
        for (int k = 0; k < 40; k++) begin
            setp($urandom_range(3), $urandom_range(6000, 10), $urandom_range(1000),
                $urandom_range(400), $urandom_range(3000, 1));
            req(k % 4 == 0 ? 0 : (k % 4));
        end
        $display("test random done");
        report_and_stop();
    end
endmodule
